//--- rcf_consts.svh
// Purpose: Offsets, field positions, reset values and cause patterns
// Assumes: Included by the reset cause package and design
// Notes: Cause patterns are {power_on, stop, watchdog, external}
`ifndef RCF_CONSTS_SVH
`define RCF_CONSTS_SVH
`define RCF_ADDR_W 8
`define RCF_OFS_STATUS 8'h00
`define RCF_OFS_EVENTS 8'h04
`define RCF_OFS_MASK 8'h08
`define RCF_CAUSE_LSB 4
`define RCF_CAUSE_MSB 7
`define RCF_EXT_BIT 0
`define RCF_NUM_EV 7
`define RCF_PAT_POR 4'h8
`define RCF_PAT_EXT 4'h1
`define RCF_PAT_WDT 4'h2
`define RCF_PAT_GPIO_STOP 4'h4
`define RCF_PAT_WDT_STOP 4'h6
`define RCF_PAT_NONE 4'h0
`define RCF_RESV_ZERO 4'h0
`define RCF_RST_EVENTS 7'h00
`define RCF_RST_MASK 7'h00
`define RCF_RESP_OKAY 2'h0
`define RCF_RESP_SLVERR 2'h2
`define RCF_WORD_PAD 24'h000000
`define RCF_MASK_PAD 25'h0000000
`endif

//--- rcf_pkg.sv
// Purpose: Types shared by the reset cause flag logic
// Assumes: rcf_consts.svh supplies the widths
// Notes: Event struct order fixes the event status bit order
`include "rcf_consts.svh"
package rcf_pkg;
  typedef struct packed {
    logic wdt_stop;
    logic gpio_stop;
    logic debug_pin_stop;
    logic debug_cmd;
    logic wdt_run;
    logic ext_pin;
    logic power_on;
  } rcf_event_type;

  typedef struct packed {
    logic [3:0] cause;
    logic [`RCF_NUM_EV-1:0] events;
    logic [`RCF_NUM_EV-1:0] mask;
    logic aw_held;
    logic [`RCF_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcf_state_type;
endpackage : rcf_pkg

//--- rcf_reset_cause.sv
// Purpose: Reset cause flags with AXI4-Lite register access and interrupt
// Assumes: Event inputs are one-cycle pulses synchronous to SYS_CLK
// Notes: Status at 0x00 holds cause flags in bits 7:4; a read clears EXTERNAL_RESET_FLAG
`include "rcf_consts.svh"
module rcf_reset_cause
  import rcf_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire rcf_event_type EVENTS,
  input wire logic [`RCF_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`RCF_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ
);

  // Highest priority event wins when several arrive together
  function automatic logic [3:0] cause_pattern(input rcf_event_type ev);
    logic [3:0] pat;
    pat = `RCF_PAT_NONE;
    if (ev.power_on || ev.debug_cmd || ev.debug_pin_stop) begin
      pat = `RCF_PAT_POR;
    end else if (ev.ext_pin) begin
      pat = `RCF_PAT_EXT;
    end else if (ev.wdt_run) begin
      pat = `RCF_PAT_WDT;
    end else if (ev.wdt_stop) begin
      pat = `RCF_PAT_WDT_STOP;
    end else if (ev.gpio_stop) begin
      pat = `RCF_PAT_GPIO_STOP;
    end
    return pat;
  endfunction : cause_pattern

  // True for the three decoded register offsets
  function automatic logic addr_mapped(input logic [`RCF_ADDR_W-1:0] a);
    logic hit;
    hit = (a == `RCF_OFS_STATUS) || (a == `RCF_OFS_EVENTS) || (a == `RCF_OFS_MASK);
    return hit;
  endfunction : addr_mapped

  rcf_state_type st;
  rcf_state_type next_st;
  logic any_event;
  logic ar_take;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [`RCF_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic status_read;

  assign any_event = |EVENTS;
  assign S_AXI_ARREADY = !st.rvalid;
  assign S_AXI_AWREADY = !st.aw_held && !st.bvalid;
  assign S_AXI_WREADY = !st.w_held && !st.bvalid;
  assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_go = (st.aw_held || aw_take) && (st.w_held || w_take) && !st.bvalid;
  assign wr_addr = st.aw_held ? st.aw_addr : S_AXI_AWADDR;
  assign wr_data = st.w_held ? st.w_data : S_AXI_WDATA[7:0];
  assign wr_lane0 = st.w_held ? st.w_lane0 : S_AXI_WSTRB[0];
  assign status_read = ar_take && (S_AXI_ARADDR == `RCF_OFS_STATUS);

  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;
  assign IRQ = |(st.events & st.mask);

  always_comb begin
    next_st = st;
    // Write channel capture, either order
    if (aw_take && !wr_go) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR;
    end
    if (w_take && !wr_go) begin
      next_st.w_held = 1'b1;
      next_st.w_data = S_AXI_WDATA[7:0];
      next_st.w_lane0 = S_AXI_WSTRB[0];
    end
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RCF_RESP_OKAY;
      unique case (wr_addr)
        `RCF_OFS_STATUS: begin
        end
        `RCF_OFS_EVENTS: begin
          if (wr_lane0) begin
            next_st.events = st.events & ~wr_data[`RCF_NUM_EV-1:0];
          end
        end
        `RCF_OFS_MASK: begin
          if (wr_lane0) begin
            next_st.mask = wr_data[`RCF_NUM_EV-1:0];
          end
        end
        default: begin
          next_st.bresp = `RCF_RESP_SLVERR;
        end
      endcase
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RCF_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `RCF_OFS_STATUS: begin
          next_st.rdata = {`RCF_WORD_PAD, st.cause, `RCF_RESV_ZERO};
        end
        `RCF_OFS_EVENTS: begin
          next_st.rdata = {`RCF_MASK_PAD, st.events};
        end
        `RCF_OFS_MASK: begin
          next_st.rdata = {`RCF_MASK_PAD, st.mask};
        end
        default: begin
          next_st.rdata = {`RCF_WORD_PAD, 8'h00};
          next_st.rresp = `RCF_RESP_SLVERR;
        end
      endcase
    end
    if (status_read) begin
      next_st.cause[`RCF_EXT_BIT] = 1'b0;
    end
    // New event overwrites all flags and beats a clear in the same cycle
    if (any_event) begin
      next_st.cause = cause_pattern(EVENTS);
    end
    next_st.events = next_st.events | EVENTS;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st <= '0;
      st.cause <= `RCF_PAT_POR;
      st.events <= `RCF_RST_EVENTS;
      st.mask <= `RCF_RST_MASK;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence ext_reset_seq;
    EVENTS.ext_pin && !EVENTS.power_on && !EVENTS.debug_cmd && !EVENTS.debug_pin_stop;
  endsequence
  sequence status_read_seq;
    status_read && !any_event;
  endsequence
  sequence read_answer_seq;
    S_AXI_RVALID && S_AXI_RDATA[`RCF_CAUSE_LSB+`RCF_EXT_BIT] == 1'b0;
  endsequence

  ext_pattern_a: assert property (ext_reset_seq |=> st.cause == `RCF_PAT_EXT)
    else $error("external reset did not give external-only pattern");
  por_clears_a: assert property (EVENTS.power_on |=> st.cause == `RCF_PAT_POR)
    else $error("power-on reset left wrong pattern");
  read_clears_ext_a: assert property (status_read_seq |=> !st.cause[`RCF_EXT_BIT])
    else $error("status read did not clear external flag");
  read_then_zero_a: assert property (status_read_seq ##1 S_AXI_RREADY && !any_event
    |=> !st.cause[`RCF_EXT_BIT])
    else $error("external flag came back after read");
  resv_zero_a: assert property (S_AXI_RVALID && $rose(S_AXI_RVALID)
    && $past(S_AXI_ARADDR) == `RCF_OFS_STATUS |-> S_AXI_RDATA[3:0] == `RCF_RESV_ZERO)
    else $error("reserved status bits not zero");
  wdt_run_a: assert property (EVENTS == rcf_event_type'(7'h04) |=> st.cause == `RCF_PAT_WDT)
    else $error("watchdog reset pattern wrong");
  dbg_cmd_a: assert property (EVENTS.debug_cmd || EVENTS.debug_pin_stop
    |=> st.cause == `RCF_PAT_POR)
    else $error("debug reset not reported as power-on");
  gpio_stop_a: assert property (EVENTS == rcf_event_type'(7'h20)
    |=> st.cause == `RCF_PAT_GPIO_STOP)
    else $error("gpio stop recovery pattern wrong");
  wdt_stop_a: assert property (EVENTS == rcf_event_type'(7'h40)
    |=> st.cause == `RCF_PAT_WDT_STOP)
    else $error("watchdog stop recovery pattern wrong");
  hold_flags_a: assert property (!any_event && !status_read |=> $stable(st.cause))
    else $error("cause flags changed without an event");
  irq_level_a: assert property (EVENTS.ext_pin && st.mask[1] |=> IRQ [*2])
    else $error("interrupt did not follow unmasked event");
  read_latency_a: assert property (ar_take |=> read_answer_seq or
    (S_AXI_RVALID ##0 !S_AXI_RDATA[`RCF_CAUSE_LSB+`RCF_EXT_BIT])
    or (S_AXI_RVALID && $past(S_AXI_ARADDR) != `RCF_OFS_STATUS)
    or (S_AXI_RVALID && $past(st.cause[`RCF_EXT_BIT])))
    else $error("read answer not one cycle after address");

  // Status read returns the flags as they stood before the clear
  rd_status_data_a: assert property (ar_take && S_AXI_ARADDR == `RCF_OFS_STATUS
    |=> S_AXI_RDATA == {`RCF_WORD_PAD, $past(st.cause), `RCF_RESV_ZERO})
    else $error("status read data wrong");
  rd_status_okay_a: assert property (ar_take && S_AXI_ARADDR == `RCF_OFS_STATUS
    |=> S_AXI_RRESP == `RCF_RESP_OKAY)
    else $error("status read response not okay");
  upper_zero_a: assert property (S_AXI_RVALID
    |-> S_AXI_RDATA[31:8] == `RCF_WORD_PAD)
    else $error("upper read data bits not zero");

  // Unmapped offsets answer with an error and change nothing
  rd_bad_addr_a: assert property (ar_take && !addr_mapped(S_AXI_ARADDR)
    |=> S_AXI_RRESP == `RCF_RESP_SLVERR && S_AXI_RDATA == '0)
    else $error("unmapped read not refused");
  wr_bad_addr_a: assert property (wr_go && !addr_mapped(wr_addr)
    |=> S_AXI_BRESP == `RCF_RESP_SLVERR)
    else $error("unmapped write not refused");
  wr_bad_mask_a: assert property (wr_go && !addr_mapped(wr_addr)
    |=> $stable(st.mask))
    else $error("unmapped write changed mask");

  // Answers stand until the master takes them
  rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
    else $error("read answer dropped before ready");
  bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped before ready");
  ar_block_a: assert property (S_AXI_RVALID
    |-> !S_AXI_ARREADY)
    else $error("read address taken while answer pending");
  aw_block_a: assert property (S_AXI_BVALID
    |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  write_answer_a: assert property (wr_go
    |=> S_AXI_BVALID)
    else $error("write response not one cycle after data");

  // Mask register follows byte lane 0 only
  mask_write_a: assert property (wr_go && wr_addr == `RCF_OFS_MASK && wr_lane0
    |=> st.mask == $past(wr_data[`RCF_NUM_EV-1:0]))
    else $error("mask write not applied");
  lane_off_a: assert property (wr_go && !wr_lane0
    |=> $stable(st.mask))
    else $error("mask changed with lane 0 off");

  // Event status bits are sticky and an event beats a clear
  event_sticky_a: assert property (any_event
    |=> (st.events & $past(EVENTS)) == $past(EVENTS))
    else $error("event status bit not set");

  // Only the external pin may leave the external flag set
  ext_only_pin_a: assert property (any_event && !EVENTS.ext_pin
    |=> !st.cause[`RCF_EXT_BIT])
    else $error("external flag set by other event");
  one_run_cause_a: assert property (EVENTS.wdt_run && !EVENTS.power_on && !EVENTS.ext_pin
    && !EVENTS.debug_cmd && !EVENTS.debug_pin_stop |=> st.cause == `RCF_PAT_WDT)
    else $error("running watchdog reset pattern wrong");

endmodule : rcf_reset_cause

//--- test_reset_cause_flags.sv
// Purpose: Self-checking bench for the reset cause flags block
// Assumes: Status 0x00, event status 0x04, mask 0x08 over AXI4-Lite
// Notes: Events are one-cycle pulses launched just after a rising edge
`include "rcf_consts.svh"
module test_reset_cause_flags
  import rcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  rcf_event_type EVENTS = '0;
  logic [`RCF_ADDR_W-1:0] S_AXI_AWADDR = '0;
  logic [`RCF_ADDR_W-1:0] S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = '0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [31:0] S_AXI_RDATA, rd;
  int fails = 0;
  int n_compared = 0;
  // Expected {power_on, stop, watchdog, external} per event, in EVENTS bit order
  logic [3:0] pats [7] = '{4'h8, 4'h1, 4'h2, 4'h8, 4'h8, 4'h4, 4'h6};

  rcf_reset_cause uut (.SYS_CLK, .RESET_N, .EVENTS, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .IRQ);

  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
    S_AXI_AWADDR <= addr;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= data;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        rsp = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
      end
    end while (S_AXI_AWVALID || S_AXI_WVALID || S_AXI_BREADY);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] addr);
    S_AXI_ARADDR <= addr;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        rd = S_AXI_RDATA;
        rsp = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
      end
    end while (S_AXI_ARVALID || S_AXI_RREADY);
  endtask : axi_read

  task automatic pulse(input int idx);
    EVENTS <= rcf_event_type'(7'h01 << idx);
    @(posedge SYS_CLK);
    EVENTS <= '0;
    @(posedge SYS_CLK);
  endtask : pulse

  task automatic test_reset;
    axi_read(8'h00);
    check(rd, 32'h00000080);
    axi_read(8'h08);
    check(rd, 32'h00000000);
    check(IRQ, 1'b0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_causes;
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      axi_read(8'h00);
      check(rd, {24'h000000, pats[i], 4'h0});
      axi_read(8'h04);
      check(rd, 32'h00000001 << i);
      axi_write(8'h04, 32'h00000001 << i);
    end
    $display("test_causes done");
  endtask : test_causes

  task automatic test_ext_clear;
    pulse(1);
    axi_read(8'h00);
    check(rd, 32'h00000010);
    axi_read(8'h00);
    check(rd, 32'h00000000);
    pulse(1);
    pulse(5);
    axi_read(8'h00);
    check(rd, 32'h00000040);
    pulse(1);
    pulse(0);
    axi_read(8'h00);
    check(rd, 32'h00000080);
    $display("test_ext_clear done");
  endtask : test_ext_clear

  task automatic test_irq_bus;
    axi_write(8'h08, 32'h00000004);
    pulse(1);
    check(IRQ, 1'b0);
    pulse(2);
    check(IRQ, 1'b1);
    S_AXI_WSTRB <= 4'h0;
    axi_write(8'h08, 32'h0000007F);
    S_AXI_WSTRB <= 4'hF;
    axi_read(8'h08);
    check(rd, 32'h00000004);
    axi_write(8'h00, 32'h000000FF);
    check(rsp, `RCF_RESP_OKAY);
    axi_read(8'h00);
    check(rd, 32'h00000020);
    axi_write(8'h04, 32'h0000007F);
    check(IRQ, 1'b0);
    axi_read(8'h0C);
    check(rsp, 2'h2);
    check(rd, 32'h00000000);
    axi_write(8'h0C, 32'h00000001);
    check(rsp, 2'h2);
    axi_write(8'h08, 32'h00000002);
    pulse(1);
    check(IRQ, 1'b1);
    axi_write(8'h04, 32'h0000007F);
    check(IRQ, 1'b0);
    $display("test_irq_bus done");
  endtask : test_irq_bus

  task automatic test_mid_reset;
    pulse(1);
    check(IRQ, 1'b1);
    RESET_N <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    check(IRQ, 1'b0);
    RESET_N <= 1'b1;
    @(posedge SYS_CLK);
    axi_read(8'h00);
    check(rd, 32'h00000080);
    axi_read(8'h08);
    check(rd, 32'h00000000);
    $display("test_mid_reset done");
  endtask : test_mid_reset

  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    fails++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    @(posedge SYS_CLK);
    test_reset();
    test_causes();
    test_ext_clear();
    test_irq_bus();
    test_mid_reset();
    complete_run();
  end
endmodule : test_reset_cause_flags
